/* logic/wdtdm_pkg.sv */
// shared constants for the watchdog, reset-cause and deadman block
package wdtdm_pkg;
   // register byte addresses on the 32-bit bus
   localparam logic [7:0] WD_CTRL_LOW_ADDR  = 8'h00;
   localparam logic [7:0] WD_CLEAR_KEY_ADDR = 8'h04;
   localparam logic [7:0] RESET_CAUSE_ADDR  = 8'h08;
   localparam logic [7:0] DM_ENABLE_ADDR    = 8'h0C;
   localparam logic [7:0] DM_PRECLEAR_ADDR  = 8'h10;
   localparam logic [7:0] DM_CLEAR_ADDR     = 8'h14;
   localparam logic [7:0] DM_STATUS_ADDR    = 8'h18;
   localparam logic [7:0] DM_COUNT_LOW_ADDR = 8'h1C;
   localparam logic [7:0] DM_COUNT_HIGH_ADDR = 8'h20;
   // field positions
   localparam int WD_ON_BIT        = 15;
   localparam int WD_RUN_DIV_LSB   = 8;
   localparam int WD_CLK_SEL_LSB   = 6;
   localparam int WD_SLP_DIV_LSB   = 1;
   localparam int WD_WIN_BIT       = 0;
   localparam int DM_ON_BIT        = 15;
   localparam int RC_TRAP_BIT      = 15;
   localparam int RC_ILLOP_BIT     = 14;
   localparam int RC_CMISM_BIT     = 9;
   localparam int RC_VREG_BIT      = 8;
   localparam int RC_PIN_BIT       = 7;
   localparam int RC_SOFT_BIT      = 6;
   localparam int RC_WD_TO_BIT     = 4;
   localparam int RC_SLEEP_BIT     = 3;
   localparam int RC_IDLE_BIT      = 2;
   localparam int RC_BROWN_BIT     = 1;
   localparam int RC_POR_BIT       = 0;
   localparam int DS_BADP_BIT      = 7;
   localparam int DS_BADC_BIT      = 6;
   localparam int DS_EVENT_BIT     = 5;
   localparam int DS_WIN_BIT       = 0;
   // writable bits of the reset-cause register
   localparam logic [15:0] RC_IMPL_MASK = 16'hC3DF;
   // reset values
   localparam logic [15:0] RC_RESET_VAL = 16'h0003;
   localparam logic [31:0] WD_CNT_RESET = 32'h0000_0000;
   localparam logic [31:0] DM_CNT_RESET = 32'h0000_0000;
   // keys
   localparam logic [15:0] WD_CLEAR_KEY = 16'h5743;
   localparam logic [7:0]  DM_PRE_KEY   = 8'h40;
   localparam logic [7:0]  DM_CLR_KEY   = 8'h08;
   // clock select codes
   localparam logic [1:0] CLK_SYS  = 2'h0;
   localparam logic [1:0] CLK_RSVD = 2'h1;
   localparam logic [1:0] CLK_FAST = 2'h2;
   localparam logic [1:0] CLK_SLOW = 2'h3;
   // window opens in the last quarter of the period
   localparam int WD_WIN_SHIFT = 2;
   // bus unmapped read value
   localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
   typedef enum logic [2:0] {
      WD_OFF  = 3'b001,
      WD_RUN  = 3'b010,
      WD_FIRE = 3'b100
   } wdtdm_wd_state_t;
endpackage

/* logic/wdtdm_sync.sv */
// two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module wdtdm_sync
   import wdtdm_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         core_clk, // system clock
   input  wire logic         rstn,     // sync reset, active low
   input  wire logic [W-1:0] d_in,     // asynchronous levels
   output logic      [W-1:0] q_out     // synchronised levels
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } wdtdm_sync_st_t;
   wdtdm_sync_st_t st_reg;
   wdtdm_sync_st_t st_next;
   always_comb begin
      st_next.s1 = d_in;
      st_next.s2 = st_reg.s1;
   end
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign q_out = st_reg.s2;
endmodule

/* logic/wdtdm_tick.sv */
// oscillator edge detector giving one-cycle watchdog count enables
`timescale 1ns/1ps
module wdtdm_tick
   import wdtdm_pkg::*;
(
   input  wire logic core_clk,  // system clock
   input  wire logic rstn,      // sync reset, active low
   input  wire logic osc_sync,  // synchronised oscillator level
   output logic      tick       // one pulse per oscillator rise
);
   typedef struct packed {
      logic last;
      logic tick;
   } wdtdm_tick_st_t;
   wdtdm_tick_st_t st_reg;
   wdtdm_tick_st_t st_next;
   always_comb begin
      st_next.last = osc_sync;
      st_next.tick = osc_sync & ~st_reg.last;
   end
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign tick = st_reg.tick;
endmodule

/* logic/wdtdm_top.sv */
// watchdog, reset-cause flags and deadman timer behind a Wishbone slave
// Behaviour
// - enable bit 15 starts/stops software watchdog
// - enable bit reads one while running
// - run postscaler selects divide by 2^n
// - run clock select: slow rc, fast rc, system
// - sleep postscaler in bits 5..1
// - divider and clock fields mirror configuration
// - window bit set by config or software
// - only 0x5743 16-bit write clears watchdog
// - watchdog time-out sets flag bit 4
// - flags record each reset source
// - power-on and brown-out flags reset to one
// - sleep or idle flag set on wake
// - regulator bit 8 drives standby output
// - software sets or clears flags, no reset
// - deadman counts fetches until match
// - 32-bit counter, match from two halves
// - deadman enabled by config, or by bit 15 unless config disables it
// - preclear key arms, else first bad flag
// - clear key after preclear restarts counter
// - wrong clear key sets second bad flag
// - event flag on expiry or bad key
// - watchdog expiry resets or wakes core
// - sleep and idle always use slow rc
// - window status reads one when armed
`timescale 1ns/1ps
module wdtdm_top
   import wdtdm_pkg::*;
(
   input  wire logic        core_clk,          // system clock, 100 MHz
   input  wire logic        rstn,              // sync reset, active low
   input  wire logic        wb_cyc_i,          // wishbone cycle
   input  wire logic        wb_stb_i,          // wishbone strobe
   input  wire logic        wb_we_i,           // wishbone write
   input  wire logic [7:0]  wb_adr_i,          // byte address
   input  wire logic [3:0]  wb_sel_i,          // byte enables
   input  wire logic [31:0] wb_dat_i,          // write data
   output logic      [31:0] wb_dat_o,          // read data
   output logic             wb_ack_o,          // acknowledge
   input  wire logic        cfg_wd_en,         // watchdog enabled by config
   input  wire logic [4:0]  cfg_run_div,       // config run postscaler
   input  wire logic [4:0]  cfg_sleep_div,     // config sleep postscaler
   input  wire logic [1:0]  cfg_clk_sel,       // config run clock select
   input  wire logic        cfg_win_en,        // config window mode
   input  wire logic        cfg_dm_en,         // deadman enabled by config
   input  wire logic        deadman_config_disable, // config disables bit 15
   input  wire logic [15:0] match_count_low_cfg,    // deadman match low
   input  wire logic [15:0] match_count_high_cfg,   // deadman match high
   input  wire logic        low_power_rc_osc,  // slow rc oscillator level
   input  wire logic        fast_rc_osc,       // fast rc oscillator level
   input  wire logic        fetch_pulse,       // one pulse per fetch
   input  wire logic        core_sleep,        // core in sleep
   input  wire logic        core_idle,         // core in idle
   input  wire logic        wake_pulse,        // core woke from save mode
   input  wire logic        por_event,         // power-on reset seen
   input  wire logic        brownout_event,    // brown-out reset seen
   input  wire logic        master_clear_pin,  // pin reset seen
   input  wire logic        soft_reset_evt,    // reset instruction seen
   input  wire logic        trap_reset_evt,    // trap conflict reset seen
   input  wire logic        illegal_op_evt,    // illegal opcode reset seen
   input  wire logic        cfg_mismatch_evt,  // config mismatch reset seen
   output logic             wd_reset_req,      // watchdog device reset
   output logic             wd_wake_req,       // watchdog wake from save
   output logic             deadman_irq,       // deadman event to core
   output logic             regulator_sleep_active // regulator on in sleep
);
   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic        wd_sw_on;
      logic        win_sw;
      wdtdm_wd_state_t wd_st;
      logic [31:0] wd_cnt;
      logic [15:0] rc;
      logic        in_sleep;
      logic        in_idle;
      logic        dm_sw_on;
      logic [31:0] dm_cnt;
      logic [7:0]  preclear_byte;
      logic [7:0]  clear_byte;
      logic        bad_preclear_flag;
      logic        bad_clear_flag;
      logic        deadman_event_flag;
      logic        wd_reset;
      logic        wd_wake;
   } wdtdm_st_t;

   wdtdm_st_t   st_reg;
   wdtdm_st_t   st_next;
   logic [1:0]  osc_sync;
   logic        slow_tick;
   logic        fast_tick;

   ////////////////////////////////////////////////////////////////////////
   // oscillator crossings and count enables
   wdtdm_sync #(.W(2)) u_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .d_in     ({fast_rc_osc, low_power_rc_osc}),
      .q_out    (osc_sync)
   );

   wdtdm_tick u_slow_tick (
      .core_clk (core_clk),
      .rstn     (rstn),
      .osc_sync (osc_sync[0]),
      .tick     (slow_tick)
   );

   wdtdm_tick u_fast_tick (
      .core_clk (core_clk),
      .rstn     (rstn),
      .osc_sync (osc_sync[1]),
      .tick     (fast_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // combinational next state
   logic        req;
   logic        wr;
   logic        wd_running;
   logic        saving;
   logic [4:0]  div_sel;
   logic [31:0] wd_limit;
   logic        wd_tick;
   logic        wd_key_ok;
   logic        wd_in_window;
   logic        dm_on;
   logic [31:0] dm_match;
   logic        dm_hit;
   logic [15:0] ctrl_rd;
   logic [15:0] stat_rd;
   logic        rc_wr;
   logic [15:0] rc_hw;

   always_comb begin
      st_next = st_reg;
      req     = wb_cyc_i & wb_stb_i & ~st_reg.ack;
      wr      = req & wb_we_i;
      saving  = core_sleep | core_idle;
      wd_running = cfg_wd_en | st_reg.wd_sw_on;
      div_sel = saving ? cfg_sleep_div : cfg_run_div;
      wd_limit = 32'h0000_0001 << div_sel;
      wd_limit = wd_limit - 32'h0000_0001;
      if (saving) begin
         wd_tick = slow_tick;
      end else begin
         case (cfg_clk_sel)
            CLK_SLOW: wd_tick = slow_tick;
            CLK_FAST: wd_tick = fast_tick;
            CLK_SYS:  wd_tick = 1'b1;
            default:  wd_tick = 1'b0;
         endcase
      end
      wd_in_window = st_reg.wd_cnt >= (wd_limit - (wd_limit >> WD_WIN_SHIFT));
      wd_key_ok = wr && wb_adr_i == WD_CLEAR_KEY_ADDR && wb_sel_i[1:0] == 2'b11
                  && wb_dat_i[15:0] == WD_CLEAR_KEY;
      dm_on    = cfg_dm_en | (st_reg.dm_sw_on & ~deadman_config_disable);
      dm_match = {match_count_high_cfg, match_count_low_cfg};
      dm_hit   = dm_on && st_reg.dm_cnt >= dm_match;
      ctrl_rd  = {wd_running, 2'b00, cfg_run_div, cfg_clk_sel,
                  cfg_sleep_div, cfg_win_en | st_reg.win_sw};
      stat_rd  = {8'h00, st_reg.bad_preclear_flag, st_reg.bad_clear_flag,
                  st_reg.deadman_event_flag, 4'h0,
                  st_reg.preclear_byte == DM_PRE_KEY};
      rc_wr    = wr && wb_adr_i == RESET_CAUSE_ADDR;
      rc_hw    = '0;

      // bus: one-cycle answer, ack drops after one cycle
      st_next.ack = req;
      st_next.rdata = BUS_ZERO;
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            WD_CTRL_LOW_ADDR:   st_next.rdata = {16'h0000, ctrl_rd};
            RESET_CAUSE_ADDR:   st_next.rdata = {16'h0000, st_reg.rc};
            DM_ENABLE_ADDR:     st_next.rdata = {16'h0000, dm_on, 15'h0000};
            DM_PRECLEAR_ADDR:   st_next.rdata = {16'h0000, st_reg.preclear_byte, 8'h00};
            DM_CLEAR_ADDR:      st_next.rdata = {24'h00_0000, st_reg.clear_byte};
            DM_STATUS_ADDR:     st_next.rdata = {16'h0000, stat_rd};
            DM_COUNT_LOW_ADDR:  st_next.rdata = {16'h0000, st_reg.dm_cnt[15:0]};
            DM_COUNT_HIGH_ADDR: st_next.rdata = {16'h0000, st_reg.dm_cnt[31:16]};
            default:            st_next.rdata = BUS_ZERO;
         endcase
      end

      // software writes to control
      if (wr && wb_adr_i == WD_CTRL_LOW_ADDR) begin
         if (wb_sel_i[1]) begin
            st_next.wd_sw_on = wb_dat_i[WD_ON_BIT];
         end
         if (wb_sel_i[0]) begin
            st_next.win_sw = wb_dat_i[WD_WIN_BIT];
         end
      end
      if (wr && wb_adr_i == DM_ENABLE_ADDR && wb_sel_i[1]) begin
         st_next.dm_sw_on = wb_dat_i[DM_ON_BIT];
      end

      ////////////////////////////////////////////////////////////////////
      // watchdog
      st_next.wd_reset = 1'b0;
      st_next.wd_wake  = 1'b0;
      case (st_reg.wd_st)
         WD_OFF: begin
            st_next.wd_cnt = WD_CNT_RESET;
            if (wd_running) begin
               st_next.wd_st = WD_RUN;
            end
         end
         WD_RUN: begin
            if (!wd_running) begin
               st_next.wd_st = WD_OFF;
            end else if (wd_key_ok) begin
               st_next.wd_cnt = WD_CNT_RESET;
               if ((cfg_win_en | st_reg.win_sw) && !wd_in_window) begin
                  st_next.wd_st = WD_FIRE;
               end
            end else if (wd_tick) begin
               if (st_reg.wd_cnt >= wd_limit) begin
                  st_next.wd_st = WD_FIRE;
               end else begin
                  st_next.wd_cnt = st_reg.wd_cnt + 32'h0000_0001;
               end
            end
         end
         WD_FIRE: begin
            st_next.wd_cnt = WD_CNT_RESET;
            rc_hw[RC_WD_TO_BIT] = 1'b1;
            if (saving) begin
               st_next.wd_wake = 1'b1;
            end else begin
               st_next.wd_reset = 1'b1;
            end
            st_next.wd_st = WD_RUN;
         end
         default: st_next.wd_st = WD_OFF;
      endcase

      ////////////////////////////////////////////////////////////////////
      // reset-cause flags; hardware set wins over software clear
      st_next.in_sleep = core_sleep;
      st_next.in_idle  = core_idle;
      rc_hw[RC_TRAP_BIT]  = trap_reset_evt;
      rc_hw[RC_ILLOP_BIT] = illegal_op_evt;
      rc_hw[RC_CMISM_BIT] = cfg_mismatch_evt;
      rc_hw[RC_PIN_BIT]   = master_clear_pin;
      rc_hw[RC_SOFT_BIT]  = soft_reset_evt;
      rc_hw[RC_POR_BIT]   = por_event;
      rc_hw[RC_BROWN_BIT] = brownout_event;
      rc_hw[RC_SLEEP_BIT] = wake_pulse & st_reg.in_sleep;
      rc_hw[RC_IDLE_BIT]  = wake_pulse & st_reg.in_idle;
      if (rc_wr) begin
         for (int i = 0; i < 16; i++) begin
            if (wb_sel_i[i/8]) begin
               st_next.rc[i] = wb_dat_i[i] & RC_IMPL_MASK[i];
            end
         end
      end
      st_next.rc = st_next.rc | (rc_hw & RC_IMPL_MASK);

      ////////////////////////////////////////////////////////////////////
      // deadman timer; flags cleared only by the clear key after preclear
      if (!dm_on) begin
         st_next.dm_cnt = DM_CNT_RESET;
      end else if (fetch_pulse && !dm_hit) begin
         st_next.dm_cnt = st_reg.dm_cnt + 32'h0000_0001;
      end
      if (wr && wb_adr_i == DM_PRECLEAR_ADDR && wb_sel_i[1]) begin
         st_next.preclear_byte = wb_dat_i[15:8];
         if (wb_dat_i[15:8] != DM_PRE_KEY) begin
            st_next.bad_preclear_flag  = 1'b1;
            st_next.deadman_event_flag = 1'b1;
         end
      end
      if (wr && wb_adr_i == DM_CLEAR_ADDR && wb_sel_i[0]) begin
         if (wb_dat_i[7:0] == DM_CLR_KEY && st_reg.preclear_byte == DM_PRE_KEY) begin
            st_next.preclear_byte = 8'h00;
            st_next.clear_byte    = 8'h00;
            st_next.dm_cnt        = DM_CNT_RESET;
            st_next.bad_preclear_flag  = 1'b0;
            st_next.bad_clear_flag     = 1'b0;
            st_next.deadman_event_flag = 1'b0;
         end else begin
            st_next.clear_byte     = wb_dat_i[7:0];
            st_next.bad_clear_flag = 1'b1;
            st_next.deadman_event_flag = 1'b1;
         end
      end
      if (dm_hit && !st_reg.deadman_event_flag) begin
         st_next.deadman_event_flag = 1'b1;
         st_next.preclear_byte      = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_reg       <= '0;
         st_reg.wd_st <= WD_OFF;
         st_reg.rc    <= RC_RESET_VAL;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign wb_dat_o     = st_reg.rdata;
   assign wb_ack_o     = st_reg.ack;
   assign wd_reset_req = st_reg.wd_reset;
   assign wd_wake_req  = st_reg.wd_wake;
   assign deadman_irq  = st_reg.deadman_event_flag;
   assign regulator_sleep_active = st_reg.rc[RC_VREG_BIT];
endmodule

/* tb/wdtdm_core_model.sv */
// core stand-in: free oscillators, fetch stage and save-mode levels
`timescale 1ns/1ps
module wdtdm_core_model (
   input  wire logic core_clk,          // system clock
   input  wire logic rstn,              // sync reset, active low
   input  wire logic fetch_en,          // fetch stage running
   input  wire logic want_sleep,        // software enters sleep
   input  wire logic want_idle,         // software enters idle
   output logic      low_power_rc_osc,  // slow rc oscillator
   output logic      fast_rc_osc,       // fast rc oscillator
   output logic      fetch_pulse,       // one pulse per fetch
   output logic      core_sleep,        // core asleep
   output logic      core_idle,         // core idle
   output logic      wake_pulse         // leaving save mode
);
   initial begin
      low_power_rc_osc = 1'b0;
      fast_rc_osc      = 1'b0;
   end
   always #65 low_power_rc_osc = ~low_power_rc_osc;
   always #23 fast_rc_osc = ~fast_rc_osc;
   // wake pulse while the level still stands, level drops after it
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         fetch_pulse <= 1'b0;
         core_sleep  <= 1'b0;
         core_idle   <= 1'b0;
         wake_pulse  <= 1'b0;
      end else begin
         fetch_pulse <= fetch_en && !fetch_pulse && !core_sleep;
         wake_pulse  <= !wake_pulse && (core_sleep && !want_sleep || core_idle && !want_idle);
         core_sleep  <= want_sleep || core_sleep && !wake_pulse;
         core_idle   <= want_idle || core_idle && !wake_pulse;
      end
   end
endmodule

/* tb/wdtdm_top_asserts.sv */
// port-level assertions for the watchdog, reset-cause and deadman block
`timescale 1ns/1ps
module wdtdm_top_asserts
   import wdtdm_pkg::*;
(
   input wire logic        core_clk,               // system clock
   input wire logic        rstn,                   // sync reset, active low
   input wire logic        wb_cyc_i,               // bus cycle
   input wire logic        wb_stb_i,               // bus strobe
   input wire logic        wb_we_i,                // bus write
   input wire logic [7:0]  wb_adr_i,               // byte address
   input wire logic [31:0] wb_dat_o,               // read data
   input wire logic        wb_ack_o,               // acknowledge
   input wire logic        fetch_pulse,            // fetch pulse
   input wire logic        core_sleep,             // core asleep
   input wire logic        core_idle,              // core idle
   input wire logic        wd_reset_req,           // watchdog reset
   input wire logic        wd_wake_req,            // watchdog wake
   input wire logic        deadman_irq,            // deadman event
   input wire logic        regulator_sleep_active  // regulator level
);
   logic [5:0] cause_q;
   logic [5:0] wr_q;
   wire        wr_now = wb_cyc_i && wb_stb_i && wb_we_i;
   // short history of writes and fetches, the only causes of flag moves
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cause_q <= 6'h00;
         wr_q    <= 6'h00;
      end else begin
         cause_q <= {cause_q[4:0], wr_now || fetch_pulse};
         wr_q    <= {wr_q[4:0], wr_now};
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_key_zero: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i == WD_CLEAR_KEY_ADDR |-> wb_dat_o == BUS_ZERO)
      else $error("clear key register read not zero");
   a_reset_run: assert property (
      wd_reset_req |-> !$past(core_sleep || core_idle) || !$past(core_sleep || core_idle, 2))
      else $error("watchdog reset while in save mode");
   a_wake_save: assert property (
      wd_wake_req |-> $past(core_sleep || core_idle) || $past(core_sleep || core_idle, 2))
      else $error("watchdog wake outside save mode");
   a_fire_pulse: assert property (
      wd_reset_req || wd_wake_req |=> !(wd_reset_req || wd_wake_req))
      else $error("watchdog request longer than one cycle");
   a_irq_cause: assert property ($rose(deadman_irq) |-> |cause_q)
      else $error("deadman event without fetch or write");
   a_irq_clear: assert property ($fell(deadman_irq) |-> |wr_q)
      else $error("deadman event dropped without a write");
   a_reg_follow: assert property ($changed(regulator_sleep_active) |-> |wr_q)
      else $error("regulator level moved without a write");
   c_reset: cover property (wd_reset_req);
   c_wake: cover property (wd_wake_req);
   c_irq: cover property ($rose(deadman_irq));
endmodule

bind wdtdm_top wdtdm_top_asserts u_chk (.core_clk(core_clk), .rstn(rstn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fetch_pulse(fetch_pulse),
   .core_sleep(core_sleep), .core_idle(core_idle), .wd_reset_req(wd_reset_req),
   .wd_wake_req(wd_wake_req), .deadman_irq(deadman_irq),
   .regulator_sleep_active(regulator_sleep_active));

/* tb/wdtdm_top_test.sv */
// self-checking bench for the watchdog, reset-cause and deadman block
`timescale 1ns/1ps
module wdtdm_top_test
   import wdtdm_pkg::*;
;
   logic        core_clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000, wb_dat_o;
   logic [4:0]  run_div = 5'h03, slp_div = 5'h01;
   logic [1:0]  csel = CLK_SYS;
   logic [15:0] m_lo = 16'h0010, m_hi = 16'h0000, rdv, exp_rc = 16'h0000;
   logic [6:0]  ev = 7'h00;
   logic        cfg_z = 1'b0, dis = 1'b0, fetch_en = 1'b0, want_sleep = 1'b0, want_idle = 1'b0;
   logic        wb_ack_o, wd_reset_req, wd_wake_req, deadman_irq, reg_act;
   logic        losc, fosc, fetch, slp, idl, wake;
   int          err_total = 0, tests_run = 0, n_rst = 0, n_wake = 0, i;
   int          rc_bit [7] = '{RC_POR_BIT, RC_BROWN_BIT, RC_PIN_BIT, RC_SOFT_BIT,
                               RC_TRAP_BIT, RC_ILLOP_BIT, RC_CMISM_BIT};

   wdtdm_top dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .cfg_wd_en(cfg_z), .cfg_run_div(run_div), .cfg_sleep_div(slp_div),
      .cfg_clk_sel(csel), .cfg_win_en(cfg_z), .cfg_dm_en(cfg_z), .deadman_config_disable(dis),
      .match_count_low_cfg(m_lo), .match_count_high_cfg(m_hi), .low_power_rc_osc(losc),
      .fast_rc_osc(fosc), .fetch_pulse(fetch), .core_sleep(slp), .core_idle(idl),
      .wake_pulse(wake), .por_event(ev[0]), .brownout_event(ev[1]), .master_clear_pin(ev[2]),
      .soft_reset_evt(ev[3]), .trap_reset_evt(ev[4]), .illegal_op_evt(ev[5]),
      .cfg_mismatch_evt(ev[6]), .wd_reset_req(wd_reset_req), .wd_wake_req(wd_wake_req),
      .deadman_irq(deadman_irq), .regulator_sleep_active(reg_act));

   wdtdm_core_model core (.core_clk(core_clk), .rstn(rstn), .fetch_en(fetch_en),
      .want_sleep(want_sleep), .want_idle(want_idle), .low_power_rc_osc(losc),
      .fast_rc_osc(fosc), .fetch_pulse(fetch), .core_sleep(slp), .core_idle(idl),
      .wake_pulse(wake));

   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (wd_reset_req === 1'b1) n_rst++;
      if (wd_wake_req === 1'b1) n_wake++;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic fail(input string m);
      err_total++;
      $display("BAD %0t %s", $time, m);
   endtask
   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) fail($sformatf("reg %h want %h", g, e));
   endtask
   task automatic chkb(input logic g, input logic e);
      tests_run++;
      if (g !== e) fail($sformatf("flag %b want %b", g, e));
   endtask
   // one classic cycle, held until ack, then one idle cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [15:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= {16'h0000, d};
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) fail("no ack");
      rdv = wb_dat_o[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b1, a, 4'h3, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      bus(1'b0, a, 4'hF, 16'h0000);
      chk16(rdv, e);
   endtask
   // eight clear-key writes, about three cycles apart
   task automatic wdt(input logic [15:0] k, input logic [3:0] s, input logic f);
      n_rst = 0;
      repeat (8) bus(1'b1, WD_CLEAR_KEY_ADDR, s, k);
      chkb(n_rst != 0, f);
   endtask
   task automatic save_trial(input logic idle, input logic [15:0] e);
      wr(RESET_CAUSE_ADDR, 16'h0000);
      wr(WD_CTRL_LOW_ADDR, 16'h8000);
      wr(WD_CLEAR_KEY_ADDR, WD_CLEAR_KEY);
      n_rst = 0;
      n_wake = 0;
      want_sleep <= !idle;
      want_idle <= idle;
      for (i = 0; i < 400 && n_wake == 0; i++) @(posedge core_clk);
      chkb(n_wake != 0, 1'b1);
      chkb(n_rst != 0, 1'b0);
      want_sleep <= 1'b0;
      want_idle <= 1'b0;
      wr(WD_CTRL_LOW_ADDR, 16'h0000);
      rdc(RESET_CAUSE_ADDR, e);
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      fail("timeout");
      close_out();
   end
   initial begin
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      rdc(RESET_CAUSE_ADDR, RC_RESET_VAL);
      rdc(WD_CTRL_LOW_ADDR, 16'h0302);
      rdc(WD_CLEAR_KEY_ADDR, 16'h0000);
      rdc(8'h3C, 16'h0000);
      wr(RESET_CAUSE_ADDR, 16'hC3DC);
      rdc(RESET_CAUSE_ADDR, 16'hC3DC);
      chkb(reg_act, 1'b1);
      chkb(wd_reset_req, 1'b0);
      wr(RESET_CAUSE_ADDR, 16'h0000);
      chkb(reg_act, 1'b0);
      for (i = 0; i < 7; i++) begin
         ev <= 7'(1 << i);
         @(posedge core_clk);
         ev <= 7'h00;
         exp_rc[rc_bit[i]] = 1'b1;
         rdc(RESET_CAUSE_ADDR, exp_rc);
      end
      wr(RESET_CAUSE_ADDR, 16'h0000);
      wr(WD_CTRL_LOW_ADDR, 16'h8000);
      wdt(WD_CLEAR_KEY, 4'h3, 1'b0);
      rdc(WD_CTRL_LOW_ADDR, 16'h8302);
      wdt(16'h5744, 4'h3, 1'b1);
      wdt(WD_CLEAR_KEY, 4'h1, 1'b1);
      rdc(RESET_CAUSE_ADDR, 16'h0010);
      wr(WD_CTRL_LOW_ADDR, 16'h8001);
      rdc(WD_CTRL_LOW_ADDR, 16'h8303);
      wdt(WD_CLEAR_KEY, 4'h3, 1'b1);
      wr(WD_CTRL_LOW_ADDR, 16'h0000);
      n_rst = 0;
      repeat (40) @(posedge core_clk);
      chkb(n_rst != 0, 1'b0);
      save_trial(1'b0, 16'h0018);
      save_trial(1'b1, 16'h0014);
      dis <= 1'b1;
      wr(DM_ENABLE_ADDR, 16'h8000);
      rdc(DM_ENABLE_ADDR, 16'h0000);
      dis <= 1'b0;
      wr(DM_ENABLE_ADDR, 16'h8000);
      rdc(DM_ENABLE_ADDR, 16'h8000);
      fetch_en <= 1'b1;
      for (i = 0; i < 200 && deadman_irq !== 1'b1; i++) @(posedge core_clk);
      fetch_en <= 1'b0;
      chkb(deadman_irq, 1'b1);
      rdc(DM_STATUS_ADDR, 16'h0020);
      rdc(DM_COUNT_LOW_ADDR, 16'h0010);
      rdc(DM_COUNT_HIGH_ADDR, 16'h0000);
      wr(DM_PRECLEAR_ADDR, 16'h4000);
      rdc(DM_STATUS_ADDR, 16'h0021);
      wr(DM_CLEAR_ADDR, 16'h0007);
      rdc(DM_STATUS_ADDR, 16'h0061);
      rdc(DM_PRECLEAR_ADDR, 16'h4000);
      rdc(DM_CLEAR_ADDR, 16'h0007);
      wr(DM_CLEAR_ADDR, 16'h0008);
      rdc(DM_STATUS_ADDR, 16'h0000);
      rdc(DM_COUNT_LOW_ADDR, 16'h0000);
      rdc(DM_CLEAR_ADDR, 16'h0000);
      chkb(deadman_irq, 1'b0);
      wr(DM_PRECLEAR_ADDR, 16'h1200);
      rdc(DM_STATUS_ADDR, 16'h00A0);
      cfg_z <= 1'b1;
      dis <= 1'b1;
      rdc(WD_CTRL_LOW_ADDR, 16'h8303);
      rdc(DM_ENABLE_ADDR, 16'h8000);
      close_out();
   end
endmodule
